// ==== axis_homing_sequencer.v ====
// homing sequencer for methods 12-14 and 17-22
`timescale 1ns/10ps
`include "axis_homing_map.vh"
module axis_homing_sequencer (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_start,
  input wire i_abort,
  input wire [7:0] i_method,
  input wire i_home_pin,
  input wire i_nlim_pin,
  input wire i_plim_pin,
  input wire i_zidx_pin,
  input wire [31:0] i_enc_pos,
  output reg o_move,
  output reg o_dir_fwd,
  output reg o_speed2,
  output reg o_busy,
  output reg o_done,
  output reg o_fault,
  output wire [31:0] o_zero_pos,
  output wire o_zero_stb
);
  // =====================================================
  // states
  localparam [2:0] ST_IDLE = 3'h0; // waiting for trigger
  localparam [2:0] ST_START = 3'h1; // synced switch levels sampled
  localparam [2:0] ST_MOVE = 3'h2; // walking the step table
  localparam [2:0] ST_ZWAIT = 3'h3; // armed, waiting for index
  localparam [2:0] ST_DONE = 3'h4; // zero found, stopped
  localparam [2:0] ST_FAULT = 3'h5; // method refused or table hole

  // =====================================================
  // pin synchronisers
  wire [3:0] pins_s; // {zidx, plim, nlim, home}
  pin_sync #(.WIDTH(4)) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_pin({i_zidx_pin, i_plim_pin, i_nlim_pin, i_home_pin}),
    .o_sync(pins_s)
  );
  wire home_s = pins_s[0];
  wire nlim_s = pins_s[1];
  wire plim_s = pins_s[2];
  wire zidx_s = pins_s[3];

  // =====================================================
  // table helpers
  // build one step entry
  function [7:0] mk;
    input dir_fwd;
    input spd2;
    input [1:0] sel;
    input lvl;
    input [1:0] act;
    begin
      mk = {1'b1, dir_fwd, spd2, sel, lvl, act};
    end
  endfunction

  // method supported by this sequencer
  function supported;
    input [7:0] m;
    begin
      case (m)
        `HM_M12, `HM_M13, `HM_M14: supported = 1'b1;
        `HM_M17, `HM_M18, `HM_M19: supported = 1'b1;
        `HM_M20, `HM_M21, `HM_M22: supported = 1'b1;
        default: supported = 1'b0; // 15, 16 and the rest
      endcase
    end
  endfunction

  // methods 12-14 turn on the negative limit during the first step of the low case
  function uses_nlim_turn;
    input [7:0] m;
    begin
      uses_nlim_turn = (m == `HM_M12) || (m == `HM_M13) ||
                       (m == `HM_M14);
    end
  endfunction

  // selected switch level
  function sw_level;
    input [1:0] sel;
    input h;
    input n;
    input p;
    begin
      case (sel)
        `HM_SEL_NLIM: sw_level = n;
        `HM_SEL_PLIM: sw_level = p;
        default: sw_level = h;
      endcase
    end
  endfunction

  // step table: forward=1, speed2=1; invalid entry ends a walk
  function [7:0] step_ent;
    input [7:0] m;
    input [1:0] cs;
    input [1:0] ix;
    reg [7:0] e;
    begin
      e = 8'h00;
      case ({m, cs, ix})
        // method 12
        {`HM_M12, `HM_CASE_LOW, 2'h0}:
          e = mk(1'b0, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_NEXT); // RULE1
        {`HM_M12, `HM_CASE_LOW, 2'h1}:
          e = mk(1'b0, 1'b1, `HM_SEL_HOME, 1'b1, `HM_ACT_ARMZ); // RULE1
        {`HM_M12, `HM_CASE_HIGH, 2'h0}:
          e = mk(1'b1, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_NEXT); // RULE2
        {`HM_M12, `HM_CASE_HIGH, 2'h1}:
          e = mk(1'b0, 1'b1, `HM_SEL_HOME, 1'b1, `HM_ACT_ARMZ); // RULE2
        {`HM_M12, `HM_CASE_LIMIT, 2'h0}:
          e = mk(1'b1, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_NEXT); // RULE3
        {`HM_M12, `HM_CASE_LIMIT, 2'h1}:
          e = mk(1'b1, 1'b0, `HM_SEL_HOME, 1'b0, `HM_ACT_NEXT); // RULE3
        {`HM_M12, `HM_CASE_LIMIT, 2'h2}:
          e = mk(1'b0, 1'b1, `HM_SEL_HOME, 1'b1, `HM_ACT_ARMZ); // RULE3
        // method 13
        {`HM_M13, `HM_CASE_LOW, 2'h0}:
          e = mk(1'b0, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_NEXT); // RULE4
        {`HM_M13, `HM_CASE_LOW, 2'h1}:
          e = mk(1'b0, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_NEXT); // RULE4
        {`HM_M13, `HM_CASE_LOW, 2'h2}:
          e = mk(1'b1, 1'b1, `HM_SEL_HOME, 1'b1, `HM_ACT_ARMZ); // RULE4
        {`HM_M13, `HM_CASE_HIGH, 2'h0}:
          e = mk(1'b0, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_NEXT); // RULE5
        {`HM_M13, `HM_CASE_HIGH, 2'h1}:
          e = mk(1'b1, 1'b1, `HM_SEL_HOME, 1'b1, `HM_ACT_ARMZ); // RULE5
        {`HM_M13, `HM_CASE_LIMIT, 2'h0}:
          e = mk(1'b1, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_NEXT); // RULE6
        {`HM_M13, `HM_CASE_LIMIT, 2'h1}:
          e = mk(1'b1, 1'b1, `HM_SEL_HOME, 1'b1, `HM_ACT_ARMZ); // RULE6
        // method 14
        {`HM_M14, `HM_CASE_LOW, 2'h0}:
          e = mk(1'b0, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_NEXT); // RULE7
        {`HM_M14, `HM_CASE_LOW, 2'h1}:
          e = mk(1'b0, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_ARMZ); // RULE7
        {`HM_M14, `HM_CASE_HIGH, 2'h0}:
          e = mk(1'b0, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_ARMZ); // RULE8
        {`HM_M14, `HM_CASE_LIMIT, 2'h0}:
          e = mk(1'b1, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_NEXT); // RULE9
        {`HM_M14, `HM_CASE_LIMIT, 2'h1}:
          e = mk(1'b0, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_ARMZ); // RULE9
        // method 17: negative limit only
        {`HM_M17, `HM_CASE_LOW, 2'h0}:
          e = mk(1'b0, 1'b0, `HM_SEL_NLIM, 1'b1, `HM_ACT_NEXT); // RULE12
        {`HM_M17, `HM_CASE_LOW, 2'h1}:
          e = mk(1'b1, 1'b1, `HM_SEL_NLIM, 1'b0, `HM_ACT_LATCH); // RULE12
        {`HM_M17, `HM_CASE_HIGH, 2'h0}:
          e = mk(1'b1, 1'b1, `HM_SEL_NLIM, 1'b0, `HM_ACT_LATCH); // RULE13
        // method 18: positive limit only
        {`HM_M18, `HM_CASE_LOW, 2'h0}:
          e = mk(1'b1, 1'b0, `HM_SEL_PLIM, 1'b1, `HM_ACT_NEXT); // RULE14
        {`HM_M18, `HM_CASE_LOW, 2'h1}:
          e = mk(1'b0, 1'b1, `HM_SEL_PLIM, 1'b0, `HM_ACT_LATCH); // RULE14
        {`HM_M18, `HM_CASE_HIGH, 2'h0}:
          e = mk(1'b0, 1'b1, `HM_SEL_PLIM, 1'b0, `HM_ACT_LATCH); // RULE15
        // method 19
        {`HM_M19, `HM_CASE_LOW, 2'h0}:
          e = mk(1'b1, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_NEXT); // RULE16
        {`HM_M19, `HM_CASE_LOW, 2'h1}:
          e = mk(1'b0, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_LATCH); // RULE16
        {`HM_M19, `HM_CASE_HIGH, 2'h0}:
          e = mk(1'b0, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_LATCH); // RULE17
        // method 20
        {`HM_M20, `HM_CASE_LOW, 2'h0}:
          e = mk(1'b1, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_LATCH); // RULE18
        {`HM_M20, `HM_CASE_HIGH, 2'h0}:
          e = mk(1'b0, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_NEXT); // RULE19
        {`HM_M20, `HM_CASE_HIGH, 2'h1}:
          e = mk(1'b1, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_LATCH); // RULE19
        // method 21
        {`HM_M21, `HM_CASE_HIGH, 2'h0}:
          e = mk(1'b1, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_LATCH); // RULE20
        {`HM_M21, `HM_CASE_LOW, 2'h0}:
          e = mk(1'b0, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_NEXT); // RULE20
        {`HM_M21, `HM_CASE_LOW, 2'h1}:
          e = mk(1'b1, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_LATCH); // RULE20
        // method 22
        {`HM_M22, `HM_CASE_HIGH, 2'h0}:
          e = mk(1'b1, 1'b1, `HM_SEL_HOME, 1'b0, `HM_ACT_NEXT); // RULE21
        {`HM_M22, `HM_CASE_HIGH, 2'h1}:
          e = mk(1'b0, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_LATCH); // RULE21
        {`HM_M22, `HM_CASE_LOW, 2'h0}:
          e = mk(1'b0, 1'b0, `HM_SEL_HOME, 1'b1, `HM_ACT_LATCH); // RULE22
        default: e = 8'h00;
      endcase
      step_ent = e;
    end
  endfunction

  // =====================================================
  // state registers
  reg [2:0] state_r; // sequencer state
  reg [7:0] method_r; // method held for the whole run
  reg [1:0] case_r; // case picked at trigger or by limit
  reg [1:0] step_r; // index into the step table
  reg zidx_d_r; // delayed index level for edge detect
  reg cap_r; // capture request to the position latch

  // =====================================================
  // current step decode
  wire [7:0] ent = step_ent(method_r, case_r, step_r);
  wire [1:0] ent_sel = ent[`HM_F_SEL_HI:`HM_F_SEL_LO];
  wire [1:0] ent_act = ent[`HM_F_ACT_HI:`HM_F_ACT_LO];
  wire cond_met = ent[`HM_F_VALID] &&
    (sw_level(ent_sel, home_s, nlim_s, plim_s) == ent[`HM_F_LVL]);
  wire z_rise = zidx_s & ~zidx_d_r; // reads second sync stage only
  // the switch that chooses the case at trigger
  wire case_sw = (method_r == `HM_M17) ? nlim_s :
                 (method_r == `HM_M18) ? plim_s : home_s;

  // =====================================================
  // sequencer
  // zero detection and the move outputs share one process so the
  // motor stops in the same cycle the capture is requested
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      method_r <= 8'h00;
      case_r <= `HM_CASE_LOW;
      step_r <= 2'h0;
      zidx_d_r <= 1'b0;
      cap_r <= 1'b0;
      o_move <= 1'b0;
      o_dir_fwd <= 1'b0;
      o_speed2 <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_fault <= 1'b0;
    end else if (i_ce) begin
      zidx_d_r <= zidx_s;
      cap_r <= 1'b0;
      if (i_abort && o_busy) begin
        // abort stops motion without a zero point
        state_r <= ST_IDLE;
        o_move <= 1'b0;
        o_busy <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE, ST_DONE, ST_FAULT: begin
            // a new trigger clears the previous result
            if (i_start) begin
              method_r <= i_method;
              o_done <= 1'b0;
              o_fault <= 1'b0;
              if (supported(i_method)) begin
                state_r <= ST_START;
                o_busy <= 1'b1;
              end else begin
                state_r <= ST_FAULT; // RULE10
                o_fault <= 1'b1; // RULE10
              end
            end
          end
          ST_START: begin
            // switch levels fixed before any motion command
            case_r <= case_sw ? `HM_CASE_HIGH : `HM_CASE_LOW; // RULE23
            step_r <= 2'h0;
            state_r <= ST_MOVE;
          end
          ST_MOVE: begin
            o_move <= ent[`HM_F_VALID];
            o_dir_fwd <= ent[`HM_F_DIR];
            o_speed2 <= ent[`HM_F_SPD];
            if (!ent[`HM_F_VALID]) begin
              // table hole: stop safely
              state_r <= ST_FAULT;
              o_move <= 1'b0;
              o_busy <= 1'b0;
              o_fault <= 1'b1;
            end else if (uses_nlim_turn(method_r) &&
                case_r == `HM_CASE_LOW && step_r == 2'h0 &&
                nlim_s && !home_s) begin
              // limit reached before home: take the turn-back path
              case_r <= `HM_CASE_LIMIT; // RULE3 RULE6 RULE9
              step_r <= 2'h0;
            end else if (cond_met) begin
              case (ent_act)
                `HM_ACT_NEXT: step_r <= step_r + 2'h1;
                `HM_ACT_ARMZ: state_r <= ST_ZWAIT;
                `HM_ACT_LATCH: begin
                  // switch edge alone fixes zero
                  cap_r <= 1'b1; // RULE11
                  o_move <= 1'b0; // RULE24
                  o_busy <= 1'b0;
                  o_done <= 1'b1; // RULE24
                  state_r <= ST_DONE;
                end
                default: state_r <= ST_FAULT;
              endcase
            end
          end
          ST_ZWAIT: begin
            // keep moving at the armed speed until the index
            if (z_rise) begin
              cap_r <= 1'b1; // RULE1 RULE2 RULE4 RULE7 RULE8
              o_move <= 1'b0; // RULE24
              o_busy <= 1'b0;
              o_done <= 1'b1; // RULE24
              state_r <= ST_DONE;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // =====================================================
  // zero point capture
  pos_capture u_cap (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_cap(cap_r),
    .i_pos(i_enc_pos),
    .o_pos(o_zero_pos),
    .o_stb(o_zero_stb)
  );
endmodule // axis_homing_sequencer

// ==== axis_homing_map.vh ====
// constants and step encoding for the axis homing sequencer
// Function
// [RULE1] m12 home low: slow reverse, fast, Z
// [RULE2] m12 home high: fast forward, reverse, Z
// [RULE3] m12 limit hit: turn, pass home, Z
// [RULE4] m13 home low: slow, fast, reverse, Z
// [RULE5] m13 home high: fast, reverse, Z
// [RULE6] m13 limit hit: turn, fast, Z
// [RULE7] m14 home low: slow, fast, Z after low
// [RULE8] m14 home high: fast reverse, Z after low
// [RULE9] m14 limit hit: turn, turn fast, Z
// [RULE10] methods 15 and 16 never move
// [RULE11] methods 17 to 22 skip Z
// [RULE12] m17 limit low: reverse, turn fast, latch
// [RULE13] m17 limit high: forward fast, latch low
// [RULE14] m18 limit low: forward, reverse fast, latch
// [RULE15] m18 limit high: reverse fast, latch low
// [RULE16] m19 home low: forward, reverse fast, latch
// [RULE17] m19 home high: reverse fast, latch low
// [RULE18] m20 home low: forward slow, latch high
// [RULE19] m20 home high: reverse, forward slow, latch
// [RULE20] m21 both cases latch on home low
// [RULE21] m22 home high: forward, reverse slow, latch
// [RULE22] m22 home low: reverse slow, latch high
// [RULE23] sample switches at trigger, pick case
// [RULE24] capture position, stop, flag done
`ifndef AXIS_HOMING_MAP_VH
`define AXIS_HOMING_MAP_VH

// =====================================================
// method codes
`define HM_M12 8'h0C
`define HM_M13 8'h0D
`define HM_M14 8'h0E
`define HM_M15 8'h0F
`define HM_M16 8'h10
`define HM_M17 8'h11
`define HM_M18 8'h12
`define HM_M19 8'h13
`define HM_M20 8'h14
`define HM_M21 8'h15
`define HM_M22 8'h16

// =====================================================
// step entry field positions (8-bit entry)
`define HM_F_VALID 7
`define HM_F_DIR 6
`define HM_F_SPD 5
`define HM_F_SEL_HI 4
`define HM_F_SEL_LO 3
`define HM_F_LVL 2
`define HM_F_ACT_HI 1
`define HM_F_ACT_LO 0

// switch selectors
`define HM_SEL_HOME 2'h0
`define HM_SEL_NLIM 2'h1
`define HM_SEL_PLIM 2'h2

// actions once the wait condition holds
`define HM_ACT_NEXT 2'h0
`define HM_ACT_LATCH 2'h1
`define HM_ACT_ARMZ 2'h2

// case indices
`define HM_CASE_LOW 2'h0
`define HM_CASE_HIGH 2'h1
`define HM_CASE_LIMIT 2'h2

// reset values
`define HM_POS_RST 32'h00000000

`endif

// ==== pin_sync.v ====
// two-flop synchroniser bank for switch and index pins
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 4
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire [WIDTH-1:0] i_pin,
  output wire [WIDTH-1:0] o_sync
);
  // =====================================================
  // per-bit synchroniser chain
  reg [WIDTH-1:0] meta_r; // first stage, read only by stage two
  reg [WIDTH-1:0] sync_r; // second stage, safe for logic
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      // metastability settles across the first flop
      always @(posedge i_clk) begin
        if (!i_rst_b) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else if (i_ce) begin
          meta_r[g] <= i_pin[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate
  assign o_sync = sync_r;
endmodule // pin_sync

// ==== pos_capture.v ====
// zero-point position capture register
`timescale 1ns/10ps
`include "axis_homing_map.vh"
module pos_capture (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_cap,
  input wire [31:0] i_pos,
  output reg [31:0] o_pos,
  output reg o_stb
);
  // =====================================================
  // capture the encoder count on request, one-cycle strobe
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_pos <= `HM_POS_RST;
      o_stb <= 1'b0;
    end else if (i_ce) begin
      o_stb <= i_cap;
      if (i_cap) begin
        o_pos <= i_pos; // RULE24
      end
    end
  end
endmodule // pos_capture

// ==== axis_homing_monitor.sv ====
// port checker for the axis homing sequencer
`timescale 1ns/10ps
module axis_homing_monitor (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_start,
  input wire [7:0] i_method,
  input wire [31:0] i_enc_pos,
  input wire o_move,
  input wire o_busy,
  input wire o_done,
  input wire o_fault,
  input wire [31:0] o_zero_pos,
  input wire o_zero_stb
);
  // =====================================================
  // one clock domain, checks paused in reset
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // reserved method codes
  wire rsv = (i_method == 8'h0F) || (i_method == 8'h10);
  // supported method codes
  wire ok_m = (i_method >= 8'h0C && i_method <= 8'h0E) ||
    (i_method >= 8'h11 && i_method <= 8'h16);
  // =====================================================
  // trigger accepted while not running
  sequence trig_ok;
    i_ce && i_start && !o_busy && ok_m;
  endsequence
  sequence trig_rsv;
    i_ce && i_start && !o_busy && rsv;
  endsequence
  a_start_busy: assert property (
    trig_ok |-> ##[1:2] (o_busy && !o_done && !o_fault)
  ) else $error("trigger not taken");
  // a latch on the first step may end the run before motion shows
  a_start_moves: assert property (
    trig_ok |-> ##[1:4] (o_move || o_done)
  ) else $error("no motion after trigger");
  a_reserved_fault: assert property (
    trig_rsv |-> ##[1:2] o_fault
  ) else $error("reserved code not refused");
  a_reserved_still: assert property (
    trig_rsv |=> !o_move [*8]
  ) else $error("reserved code moved the axis");
  a_done_stops_motion: assert property (
    $rose(o_done) |-> !o_move && !o_busy
  ) else $error("motion still commanded at zero latch");
  // capture lags the latch edge by one register stage
  a_zero_capture: assert property (
    $rose(o_done) |=> o_zero_stb && o_zero_pos == $past(i_enc_pos, 2)
  ) else $error("zero position not captured");
  a_strobe_single: assert property (
    o_zero_stb |-> o_done ##1 !o_zero_stb
  ) else $error("zero strobe wrong");
  a_done_holds: assert property (
    o_done && !(i_ce && i_start) |=> o_done
  ) else $error("complete flag dropped");
  a_fault_holds: assert property (
    o_fault && !(i_ce && i_start) |=> o_fault
  ) else $error("fault flag dropped");
  a_move_in_run: assert property (
    o_move |-> o_busy && !o_done
  ) else $error("motion outside a run");
endmodule // axis_homing_monitor

bind axis_homing_sequencer axis_homing_monitor u_mon (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_start(i_start),
  .i_method(i_method), .i_enc_pos(i_enc_pos), .o_move(o_move),
  .o_busy(o_busy), .o_done(o_done), .o_fault(o_fault),
  .o_zero_pos(o_zero_pos), .o_zero_stb(o_zero_stb)
);

// ==== axis_motor_model.sv ====
// motor axis model: moves on command, drives switches and index
`timescale 1ns/10ps
module axis_motor_model (
  input wire logic i_clk,
  input wire logic i_load,
  input wire logic [31:0] i_load_pos,
  input wire logic i_move,
  input wire logic i_dir_fwd,
  input wire logic i_speed2,
  output logic o_home,
  output logic o_nlim,
  output logic o_plim,
  output logic o_zidx,
  output logic [31:0] o_pos
);
  // =====================================================
  // geometry: home cam 40..47, ends at 0 and 100
  logic [2:0] tick_r; // step divider
  logic signed [31:0] p; // signed view of position
  assign p = o_pos;
  assign o_home = (p >= 40) && (p <= 47);
  assign o_nlim = (p <= 0);
  assign o_plim = (p >= 100);
  // index one count wide, every 8 counts: one pulse falls inside
  // the home cam (44) and one just below it (36), so methods that
  // want the index while home is high and those that want it after
  // home drops each see a distinct zero
  assign o_zidx = (o_pos[2:0] == 3'h4);
  // =====================================================
  // slow step every 8 cycles, fast every 4: a step never lands
  // inside the sequencer's reaction time, so zero is exact
  initial begin
    o_pos = 32'h00000000;
    tick_r = 3'h0;
  end
  always @(posedge i_clk) begin
    if (i_load) begin
      o_pos <= i_load_pos;
      tick_r <= 3'h0;
    end else if (i_move) begin
      tick_r <= tick_r + 3'h1;
      if (tick_r[1:0] == 2'h3 && (i_speed2 || tick_r[2])) begin
        o_pos <= i_dir_fwd ? o_pos + 32'h1 : o_pos - 32'h1;
      end
    end
  end
endmodule // axis_motor_model

// ==== testbench.sv ====
// self-checking bench for the axis homing sequencer
`timescale 1ns/10ps
module testbench;
  // =====================================================
  // stimulus and observed signals
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_start = 1'b0;
  logic i_abort = 1'b0;
  logic ce = 1'b1; // clock enable, dropped once to test the freeze
  logic [7:0] i_method = 8'h00;
  logic load = 1'b0; // reposition the axis
  logic [31:0] load_pos = 32'h00000000;
  wire home, nlim, plim, zidx;
  wire o_move, o_dir_fwd, o_speed2, o_busy, o_done, o_fault, o_zero_stb;
  wire [31:0] enc_pos, o_zero_pos;
  int errors = 0;
  int cmp_count = 0;
  int stb_n = 0; // zero strobes seen
  int move_n = 0; // cycles with motion
  logic [7:0] bad [3] = '{8'h0F, 8'h10, 8'h0B}; // refused codes
  // =====================================================
  // method, start, zero, first direction and speed
  typedef struct packed {
    logic [7:0] m;
    logic [7:0] p0;
    logic [7:0] z;
    logic [1:0] ds;
  } row_t;
  row_t rows [21] = '{
    '{8'h0C,8'h3C,8'h2C,2'h0},'{8'h0C,8'h2D,8'h2C,2'h3},
    '{8'h0C,8'h1E,8'h2C,2'h0},'{8'h0D,8'h3C,8'h2C,2'h0},
    '{8'h0D,8'h2D,8'h2C,2'h1},'{8'h0D,8'h1E,8'h2C,2'h0},
    '{8'h0E,8'h3C,8'h24,2'h0},'{8'h0E,8'h2D,8'h24,2'h1},
    '{8'h0E,8'h1E,8'h24,2'h0},'{8'h11,8'h0A,8'h01,2'h0},
    '{8'h11,8'hFE,8'h01,2'h3},'{8'h12,8'h5A,8'h63,2'h2},
    '{8'h12,8'h66,8'h63,2'h1},'{8'h13,8'h1E,8'h27,2'h2},
    '{8'h13,8'h2D,8'h27,2'h1},'{8'h14,8'h1E,8'h28,2'h2},
    '{8'h14,8'h2D,8'h28,2'h1},'{8'h15,8'h2D,8'h30,2'h3},
    '{8'h15,8'h3C,8'h30,2'h0},'{8'h16,8'h2D,8'h2F,2'h3},
    '{8'h16,8'h3C,8'h2F,2'h0}
  };
  // =====================================================
  // clock, design and axis
  always #2.5 i_clk = ~i_clk;
  axis_homing_sequencer u_axis_homing_sequencer (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_start(i_start),
    .i_abort(i_abort), .i_method(i_method), .i_home_pin(home),
    .i_nlim_pin(nlim), .i_plim_pin(plim), .i_zidx_pin(zidx),
    .i_enc_pos(enc_pos), .o_move(o_move), .o_dir_fwd(o_dir_fwd),
    .o_speed2(o_speed2), .o_busy(o_busy), .o_done(o_done),
    .o_fault(o_fault), .o_zero_pos(o_zero_pos), .o_zero_stb(o_zero_stb)
  );
  axis_motor_model u_axis_motor_model (
    .i_clk(i_clk), .i_load(load), .i_load_pos(load_pos),
    .i_move(o_move), .i_dir_fwd(o_dir_fwd), .i_speed2(o_speed2),
    .o_home(home), .o_nlim(nlim), .o_plim(plim), .o_zidx(zidx),
    .o_pos(enc_pos)
  );
  // count strobes and motion cycles
  always @(posedge i_clk) begin
    if (o_zero_stb === 1'b1) stb_n++;
    if (o_move === 1'b1) move_n++;
  end
  // =====================================================
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // place the axis, let synchronisers settle, then trigger
  task automatic go(input logic [7:0] m, input logic [7:0] p0);
    load_pos = {{24{p0[7]}}, p0};
    load = 1'b1;
    @(negedge i_clk);
    load = 1'b0;
    repeat (4) @(negedge i_clk);
    i_method = m;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
  endtask
  // one homing run; flt marks a code that must be refused
  task automatic run(input row_t r, input logic flt);
    int n;
    int m0;
    int s0;
    m0 = move_n;
    s0 = stb_n;
    go(r.m, r.p0);
    for (n = 0; n < 20 && o_move !== 1'b1 && o_fault !== 1'b1; n++) begin
      @(negedge i_clk);
    end
    if (flt) begin
      repeat (6) @(negedge i_clk);
      chk("fault", 32'h1, {31'h0, o_fault});
      chk("move_cycles", 32'h0, move_n - m0);
    end else begin
      chk("first_move", 32'h3, {30'h0, o_move, o_busy});
      chk("dir_speed", {30'h0, r.ds}, {30'h0, o_dir_fwd, o_speed2});
      for (n = 0; n < 2000 && o_done !== 1'b1; n++) begin
        @(negedge i_clk);
      end
      if (o_done !== 1'b1) begin
        errors++;
        wrap_up;
      end
      repeat (2) @(negedge i_clk);
      chk("zero_pos", {24'h0, r.z}, o_zero_pos);
      chk("zero_strobes", 32'h1, stb_n - s0);
      chk("stopped", 32'h1, {30'h0, o_move, o_done});
    end
  endtask
  // =====================================================
  // main sequence
  initial begin
    repeat (10) @(negedge i_clk);
    i_rst_b = 1'b1;
    foreach (rows[k]) run(rows[k], 1'b0);
    // refused codes, taken straight after a completed run
    foreach (bad[k]) run(row_t'{bad[k], 8'h3C, 8'h00, 2'h0}, 1'b1);
    // a reserved trigger while busy is ignored, then abort
    go(8'h13, 8'h1E);
    repeat (20) @(negedge i_clk);
    i_method = 8'h0F;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("busy_no_fault", 32'h2, {30'h0, o_busy, o_fault});
    // enable low freezes the run, even against an abort request
    ce = 1'b0;
    i_abort = 1'b1;
    repeat (4) @(negedge i_clk);
    i_abort = 1'b0;
    ce = 1'b1;
    @(negedge i_clk);
    chk("ce_frozen", 32'h3, {30'h0, o_busy, o_move});
    i_abort = 1'b1;
    @(negedge i_clk);
    i_abort = 1'b0;
    repeat (3) @(negedge i_clk);
    chk("aborted", 32'h0, {29'h0, o_busy, o_move, o_done});
    // reset in mid-run clears every output, then a clean rerun
    go(8'h14, 8'h1E);
    repeat (20) @(negedge i_clk);
    i_rst_b = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("reset_flags", 32'h0, {26'h0, o_move, o_dir_fwd, o_speed2,
      o_busy, o_done, o_fault});
    chk("reset_pos", 32'h0, o_zero_pos);
    i_rst_b = 1'b1;
    run(rows[0], 1'b0);
    wrap_up;
  end
endmodule // testbench
